//--- zac_pkg.sv
/*
 * Constants shared by the converter control block: register indices,
 * field positions, reset and preset values, sequencer timing.
 * Assumes a 100 MHz pclk and an APB master with 32-bit data.
 */
package zac_pkg;
   // ************************************************************
   // Register indices (byte address is four times the index)
   // ************************************************************
   localparam logic [2:0] ZAC_IDX_RESULT_LOW = 3'h0;
   localparam logic [2:0] ZAC_IDX_RESULT_HIGH = 3'h1;
   localparam logic [2:0] ZAC_IDX_CONVERSION_SETUP = 3'h2;
   localparam logic [2:0] ZAC_IDX_POWER_BIAS_SETUP = 3'h3;
   localparam logic [2:0] ZAC_IDX_CLOCK_STAGE2_SETUP = 3'h4;
   localparam logic [2:0] ZAC_IDX_STAGE1_STAGE3_GAIN = 3'h5;
   localparam logic [2:0] ZAC_IDX_STAGE3_OFFSET_SETUP = 3'h6;
   localparam logic [2:0] ZAC_IDX_MUX_AND_FLAG_SETUP = 3'h7;
   localparam logic [7:0] ZAC_ADDR_LAST = 8'h1C;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int ZAC_START_BIT = 7;
   localparam int ZAC_FREE_RUNNING_BIT = 1;
   localparam int ZAC_BUSY_BIT = 7;
   localparam int ZAC_PRESET_BIT = 6;
   localparam int ZAC_ENABLE_CONV_BIT = 0;

   // ************************************************************
   // Values after reset and in preset mode, plus the result saturation codes
   // ************************************************************
   localparam logic [1:0] ZAC_NELCONV_RST = 2'h1;
   localparam logic [2:0] ZAC_OSR_RST = 3'h2;
   localparam logic ZAC_FREE_RUNNING_RST = 1'b0;
   localparam logic [1:0] ZAC_BIAS_RST = 2'h3;
   localparam logic [3:0] ZAC_ENABLE_RST = 4'h0;
   localparam logic [3:0] ZAC_ENABLE_PRESET = 4'h1;
   localparam logic [1:0] ZAC_PRESCALER_RST = 2'h0;
   localparam logic [1:0] ZAC_GAIN2_RST = 2'h0;
   localparam logic [3:0] ZAC_OFF2_RST = 4'h0;
   localparam logic ZAC_GAIN1_RST = 1'b0;
   localparam logic [6:0] ZAC_GAIN3_RST = 7'h0C;
   localparam logic [6:0] ZAC_OFF3_RST = 7'h00;
   localparam logic [4:0] ZAC_INPUT_SEL_RST = 5'h00;
   localparam logic ZAC_REF_SEL_RST = 1'b0;
   localparam logic [15:0] ZAC_RESULT_RST = 16'h0000;
   localparam logic [15:0] ZAC_FULL_POS = 16'h7FFF;
   localparam logic [15:0] ZAC_FULL_NEG = 16'h8000;

   // ************************************************************
   // Sequencer timing in sample clock periods, plus divider and scaling constants
   // ************************************************************
   localparam logic [10:0] ZAC_INIT_PERIODS = 11'h005;
   localparam logic [10:0] ZAC_END_PERIODS = 11'h005;
   localparam logic [10:0] ZAC_BASE_OSR = 11'h008;
   localparam logic [7:0] ZAC_FS_PER_PSCK = 8'h04;
   localparam int ZAC_NORM_BITS = 15;

   typedef enum logic [1:0] {
      ZAC_IDLE,
      ZAC_INIT,
      ZAC_CONV,
      ZAC_TERM
   } zac_state_t;
endpackage

//--- zac_control.sv
/*
 * Control and register front end of the gain-stage and incremental
 * sigma-delta acquisition chain, reached over APB.
 * Assumes pclk is the internal oscillator, modulator_bit comes from the
 * analog modulator (asynchronous), and the analog blocks take the
 * registered setting outputs directly.
 */
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/1ps
module zac_control
   import zac_pkg::*;
(
   // Clock, reset, clock enable
   input wire logic pclk,
   input wire logic presetn,
   input wire logic clk_en,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Analog modulator
   input wire logic modulator_bit,
   output logic crossed_inputs,
   output logic sample_tick,
   output logic conv_done,
   // Analog settings
   output logic [3:0] power_enable,
   output logic [2:0] stage_bypass,
   output logic stage_reset,
   output logic [1:0] stage_bias_scale,
   output logic [1:0] converter_bias_scale,
   output logic [1:0] prescaler_select,
   output logic first_stage_gain,
   output logic [1:0] second_stage_gain,
   output logic [3:0] second_stage_offset,
   output logic [6:0] third_stage_gain,
   output logic [6:0] third_stage_offset,
   output logic [4:0] input_selector,
   output logic reference_selector,
   output logic busy
);
   import zac_pkg::*;

   // ************************************************************
   // Bus decode
   // ************************************************************
   logic [1:0] nelconv_reg;
   logic [2:0] osr_reg;
   logic free_running_reg;
   logic [15:0] result_reg;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic mapped;
   logic wr_fire;
   logic [2:0] idx;
   logic [7:0] wbyte;
   logic [7:0] rd_next;
   logic start_req;
   logic preset_req;
   logic abort;
   logic [1:0] mod_sync_reg;
   logic [7:0] div_cnt_reg;
   logic [7:0] div_len;
   logic tick_reg;
   zac_state_t state_reg;
   logic [10:0] phase_cnt_reg;
   logic [2:0] conv_idx_reg;
   logic crossed_reg;
   logic signed [15:0] acc_reg;
   logic [10:0] smax;
   logic [3:0] norm_exp;
   logic signed [19:0] scaled;
   logic busy_reg;
   logic done_reg;
   logic stage_reset_reg;

   assign mapped = (paddr <= ZAC_ADDR_LAST) && (paddr[1:0] == 2'h0);
   assign idx = paddr[4:2];
   assign wbyte = pwdata[7:0];
   // Access phase completes at the edge where pready is seen high
   assign wr_fire = clk_en && psel && penable && pready_reg && pwrite && mapped;
   assign start_req = wr_fire && (idx == ZAC_IDX_CONVERSION_SETUP) &&
      wbyte[ZAC_START_BIT];
   assign preset_req = wr_fire && (idx == ZAC_IDX_MUX_AND_FLAG_SETUP) &&
      wbyte[ZAC_PRESET_BIT];
   // Powering the converter down is the only path that kills a run;
   // a preset write powers the converter itself, so it is never an abort
   assign abort = !power_enable[ZAC_ENABLE_CONV_BIT] && !preset_req;

   // Read mux; write-only trigger bits and reserved bits read zero
   always_comb begin
      rd_next = 8'h00;
      unique case (idx)
         ZAC_IDX_RESULT_LOW: rd_next = result_reg[7:0];
         ZAC_IDX_RESULT_HIGH: rd_next = result_reg[15:8];
         ZAC_IDX_CONVERSION_SETUP: rd_next = {1'b0, nelconv_reg, osr_reg, free_running_reg, 1'b0};
         ZAC_IDX_POWER_BIAS_SETUP: rd_next = {converter_bias_scale, stage_bias_scale,
            power_enable};
         ZAC_IDX_CLOCK_STAGE2_SETUP: rd_next = {prescaler_select, second_stage_gain,
            second_stage_offset};
         ZAC_IDX_STAGE1_STAGE3_GAIN: rd_next = {first_stage_gain, third_stage_gain};
         ZAC_IDX_STAGE3_OFFSET_SETUP: rd_next = {1'b0, third_stage_offset};
         ZAC_IDX_MUX_AND_FLAG_SETUP: rd_next = {busy_reg, 1'b0, input_selector,
            reference_selector};
      endcase
   end

   // ************************************************************
   // APB answer: one wait-free access phase after setup
   // ************************************************************
   // Read data is captured in setup so prdata comes from a flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h0000_0000;
      end else if (clk_en) begin
         // A setup cycle lost to clk_en low is answered late, never skipped
         if (psel && !pready_reg) begin
            pready_reg <= 1'b1;
            pslverr_reg <= !mapped;
            prdata_reg <= (mapped && !pwrite) ? {24'h00_0000, rd_next} : 32'h0000_0000;
         end else begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
         end
      end
   end

   // ************************************************************
   // Setup registers
   // ************************************************************
   // Preset reloads defaults but loads the selectors from the same write
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nelconv_reg <= ZAC_NELCONV_RST;
         osr_reg <= ZAC_OSR_RST;
         free_running_reg <= ZAC_FREE_RUNNING_RST;
         converter_bias_scale <= ZAC_BIAS_RST;
         stage_bias_scale <= ZAC_BIAS_RST;
         power_enable <= ZAC_ENABLE_RST;
         prescaler_select <= ZAC_PRESCALER_RST;
         second_stage_gain <= ZAC_GAIN2_RST;
         second_stage_offset <= ZAC_OFF2_RST;
         first_stage_gain <= ZAC_GAIN1_RST;
         third_stage_gain <= ZAC_GAIN3_RST;
         third_stage_offset <= ZAC_OFF3_RST;
         input_selector <= ZAC_INPUT_SEL_RST;
         reference_selector <= ZAC_REF_SEL_RST;
      end else if (preset_req) begin
         nelconv_reg <= ZAC_NELCONV_RST;
         osr_reg <= ZAC_OSR_RST;
         free_running_reg <= ZAC_FREE_RUNNING_RST;
         converter_bias_scale <= ZAC_BIAS_RST;
         stage_bias_scale <= ZAC_BIAS_RST;
         power_enable <= ZAC_ENABLE_PRESET;
         prescaler_select <= ZAC_PRESCALER_RST;
         second_stage_gain <= ZAC_GAIN2_RST;
         second_stage_offset <= ZAC_OFF2_RST;
         first_stage_gain <= ZAC_GAIN1_RST;
         third_stage_gain <= ZAC_GAIN3_RST;
         third_stage_offset <= ZAC_OFF3_RST;
         input_selector <= wbyte[5:1];
         reference_selector <= wbyte[0];
      end else if (wr_fire) begin
         unique case (idx)
            ZAC_IDX_CONVERSION_SETUP: begin
               nelconv_reg <= wbyte[6:5];
               osr_reg <= wbyte[4:2];
               free_running_reg <= wbyte[ZAC_FREE_RUNNING_BIT];
            end
            ZAC_IDX_POWER_BIAS_SETUP: begin
               converter_bias_scale <= wbyte[7:6];
               stage_bias_scale <= wbyte[5:4];
               power_enable <= wbyte[3:0];
            end
            ZAC_IDX_CLOCK_STAGE2_SETUP: begin
               prescaler_select <= wbyte[7:6];
               second_stage_gain <= wbyte[5:4];
               second_stage_offset <= wbyte[3:0];
            end
            ZAC_IDX_STAGE1_STAGE3_GAIN: begin
               first_stage_gain <= wbyte[7];
               third_stage_gain <= wbyte[6:0];
            end
            ZAC_IDX_STAGE3_OFFSET_SETUP: third_stage_offset <= wbyte[6:0];
            ZAC_IDX_MUX_AND_FLAG_SETUP: begin
               input_selector <= wbyte[5:1];
               reference_selector <= wbyte[0];
            end
            default: ;
         endcase
      end
   end

   // Gain stages restart after any write to register indices three to seven
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage_reset_reg <= 1'b0;
      end else if (clk_en) begin
         stage_reset_reg <= wr_fire && (idx >= ZAC_IDX_POWER_BIAS_SETUP);
      end
   end

   // Bypass follows the enable one edge later, so it is a flop too
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stage_bypass <= 3'h7;
      end else if (clk_en) begin
         stage_bypass <= ~power_enable[3:1];
      end
   end

   // ************************************************************
   // Sample clock and modulator input
   // ************************************************************
   // Divider length: prescale times four pclk cycles per sample
   always_comb begin
      unique case (prescaler_select)
         2'h0: div_len = ZAC_FS_PER_PSCK;
         2'h1: div_len = ZAC_FS_PER_PSCK << 1;
         2'h2: div_len = ZAC_FS_PER_PSCK << 3;
         2'h3: div_len = ZAC_FS_PER_PSCK << 5;
      endcase
   end

   // Divider is held in reset while the converter is unpowered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt_reg <= 8'h00;
         tick_reg <= 1'b0;
      end else if (clk_en) begin
         if (abort || div_cnt_reg >= div_len - 8'h01) begin
            div_cnt_reg <= 8'h00;
            tick_reg <= !abort;
         end else begin
            div_cnt_reg <= div_cnt_reg + 8'h01;
            tick_reg <= 1'b0;
         end
      end
   end

   // Modulator bit is asynchronous; only the second flop is used
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mod_sync_reg <= 2'h0;
      end else if (clk_en) begin
         mod_sync_reg <= {mod_sync_reg[0], modulator_bit};
      end
   end

   // ************************************************************
   // Conversion sequencer
   // ************************************************************
   assign smax = ZAC_BASE_OSR << osr_reg;
   assign norm_exp = 4'(nelconv_reg) + 4'(osr_reg) + 4'h3;

   // Init, elementary conversions of smax+1 periods, termination
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= ZAC_IDLE;
         phase_cnt_reg <= 11'h000;
         conv_idx_reg <= 3'h0;
         crossed_reg <= 1'b0;
         acc_reg <= 16'sh0000;
      end else if (clk_en) begin
         if (abort) begin
            state_reg <= ZAC_IDLE;
         end else if (start_req || preset_req) begin
            state_reg <= ZAC_INIT;
            phase_cnt_reg <= 11'h000;
            conv_idx_reg <= 3'h0;
            crossed_reg <= 1'b0;
            acc_reg <= 16'sh0000;
         end else if (tick_reg) begin
            unique case (state_reg)
               ZAC_IDLE: ;
               ZAC_INIT: begin
                  if (phase_cnt_reg == ZAC_INIT_PERIODS - 11'h001) begin
                     state_reg <= ZAC_CONV;
                     phase_cnt_reg <= 11'h000;
                  end else begin
                     phase_cnt_reg <= phase_cnt_reg + 11'h001;
                  end
               end
               ZAC_CONV: begin
                  // Crossed inputs invert the bit sense, so offset cancels
                  if (phase_cnt_reg < smax) begin
                     acc_reg <= (mod_sync_reg[1] ^ crossed_reg) ? acc_reg + 16'sh0001 :
                        acc_reg - 16'sh0001;
                  end
                  if (phase_cnt_reg == smax) begin
                     phase_cnt_reg <= 11'h000;
                     crossed_reg <= !crossed_reg;
                     if (conv_idx_reg == 3'((4'h1 << nelconv_reg) - 4'h1)) begin
                        state_reg <= ZAC_TERM;
                     end else begin
                        conv_idx_reg <= conv_idx_reg + 3'h1;
                     end
                  end else begin
                     phase_cnt_reg <= phase_cnt_reg + 11'h001;
                  end
               end
               ZAC_TERM: begin
                  if (phase_cnt_reg == ZAC_END_PERIODS - 11'h001) begin
                     phase_cnt_reg <= 11'h000;
                     conv_idx_reg <= 3'h0;
                     acc_reg <= 16'sh0000;
                     state_reg <= free_running_reg ? ZAC_INIT : ZAC_IDLE;
                  end else begin
                     phase_cnt_reg <= phase_cnt_reg + 11'h001;
                  end
               end
            endcase
         end
      end
   end

   // Mean of all samples scaled to 16 bits, then clamped
   assign scaled = 20'(acc_reg) <<< (ZAC_NORM_BITS - int'(norm_exp));

   // Result, busy flag and done pulse at the end of termination
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result_reg <= ZAC_RESULT_RST;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
      end else if (clk_en) begin
         done_reg <= 1'b0;
         if (abort) begin
            busy_reg <= 1'b0;
         end else if (start_req || preset_req) begin
            busy_reg <= 1'b1;
         end else if (tick_reg && state_reg == ZAC_TERM &&
               phase_cnt_reg == ZAC_END_PERIODS - 11'h001) begin
            // Busy drops for a cycle even in continuous mode to mark the edge
            busy_reg <= 1'b0;
            done_reg <= 1'b1;
            if (scaled > 20'sh07FFF) begin
               result_reg <= ZAC_FULL_POS;
            end else if (scaled < -20'sh08000) begin
               result_reg <= ZAC_FULL_NEG;
            end else begin
               result_reg <= scaled[15:0];
            end
         end else if (state_reg != ZAC_IDLE) begin
            busy_reg <= 1'b1;
         end
      end
   end

   // ************************************************************
   // Output drive
   // ************************************************************
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign crossed_inputs = crossed_reg;
   assign sample_tick = tick_reg;
   assign conv_done = done_reg;
   assign stage_reset = stage_reset_reg;
   assign busy = busy_reg;

   // ************************************************************
   // Assertions
   // ************************************************************
   a_abort_clears_busy: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && !power_enable[0] && !preset_req |=> !busy_reg && state_reg == ZAC_IDLE)
      else $error("busy stays set with converter powered down");
   a_start_sets_busy: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && start_req && power_enable[0] |=> busy_reg && state_reg == ZAC_INIT)
      else $error("start did not launch the converter");
   a_preset_keeps_sel: assert property (@(posedge pclk) disable iff (!presetn)
      preset_req |=> input_selector == $past(wbyte[5:1]) &&
         reference_selector == $past(wbyte[0]) && third_stage_gain == ZAC_GAIN3_RST)
      else $error("preset mode lost the selectors or defaults");
   a_done_busy_fall: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(done_reg) |-> $fell(busy_reg))
      else $error("done pulse without busy falling");
   a_stage_reset_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      wr_fire && idx == ZAC_IDX_STAGE1_STAGE3_GAIN |=> stage_reset_reg)
      else $error("setup write did not reset gain stages");
   a_bypass_follows: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && !power_enable[3] |=> stage_bypass[2])
      else $error("disabled stage not bypassed");
   a_result_range: assert property (@(posedge pclk) disable iff (!presetn)
      done_reg && $past(scaled) > 20'sh07FFF |-> result_reg == ZAC_FULL_POS)
      else $error("positive overflow not saturated");
   a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
      clk_en && psel && !penable ##1 clk_en && psel && penable |-> pready_reg)
      else $error("access phase not answered at once");
   a_start_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
      pready_reg && !pwrite && idx == ZAC_IDX_CONVERSION_SETUP |-> !prdata_reg[7])
      else $error("start bit read back as one");
endmodule // zac_control

//--- zac_mod_model.sv
/* Stand-in for the analog modulator that feeds zac_control.
   Assumes sample_tick pulses once per sample period. */
`timescale 1ns/1ps
module zac_mod_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Pacing from the block
   input wire logic sample_tick,
   // Bitstream back
   output logic modulator_bit
);
   logic [2:0] phase_reg;
   // Five ones then three zeros in every eight samples, one step per sample
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_reg <= 3'h0;
      end else if (sample_tick) begin
         phase_reg <= phase_reg + 3'h1;
      end
   end
   assign modulator_bit = (phase_reg < 3'h5);
endmodule // zac_mod_model

//--- tb_zoom_adc_control_regs.sv
/* Self-checking bench for zac_control, driven over APB.
   Assumes zac_pkg and zac_mod_model are compiled first. */
`timescale 1ns/1ps
module tb_zoom_adc_control_regs;
   import zac_pkg::*;
   // ************************************************************
   // Signals, design and modulator
   // ************************************************************
   logic pclk = 1'b0, presetn = 1'b0, clk_en = 1'b1;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00, d;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, err, modulator_bit, crossed_inputs, sample_tick, conv_done;
   logic stage_reset, first_stage_gain, reference_selector, busy;
   logic [3:0] power_enable, second_stage_offset;
   logic [2:0] stage_bypass, i;
   logic [1:0] stage_bias_scale, converter_bias_scale, prescaler_select, second_stage_gain;
   logic [6:0] third_stage_gain, third_stage_offset;
   logic [4:0] input_selector;
   logic [7:0] rst_exp [8] = '{8'h00, 8'h00, 8'h28, 8'hF0, 8'h00, 8'h0C, 8'h00, 8'h00};
   int fails = 0, checked = 0, n;
   zac_control i_zac_control (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .modulator_bit, .crossed_inputs, .sample_tick,
      .conv_done, .power_enable, .stage_bypass, .stage_reset, .stage_bias_scale,
      .converter_bias_scale, .prescaler_select, .first_stage_gain, .second_stage_gain,
      .second_stage_offset, .third_stage_gain, .third_stage_offset, .input_selector,
      .reference_selector, .busy);
   zac_mod_model i_zac_mod_model (.pclk, .presetn, .sample_tick, .modulator_bit);
   always #5 pclk = ~pclk;
   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // One APB transfer; request held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] v);
      int k;
      k = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, v};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) chk("pready", pready, 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic logic [7:0] adr(input logic [2:0] x);
      return {3'h0, x, 2'b00};
   endfunction
   // Mean of +1/-1 samples as a fraction of full scale
   function automatic logic [15:0] mean_code(input int ones, input int total);
      return 16'(((2 * ones - total) * 32768) / total);
   endfunction
   // Wait for the done pulse; running out of time counts as a mismatch
   task automatic wait_done;
      n = 0;
      while (conv_done !== 1'b1 && n < 3000) begin
         @(posedge pclk);
         n++;
      end
      chk("conv_done", conv_done, 1'b1);
   endtask
   task automatic wrap_up;
      if (fails == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // ************************************************************
   // Main sequence
   // ************************************************************
   initial begin
      void'($urandom(44));
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      #1 chk("bypass_rst", stage_bypass, 3'b111);
      for (int j = 0; j < 8; j++) begin
         apb(1'b0, adr(j[2:0]), 8'h00);
         chk("reset_value", rd[7:0], rst_exp[j]);
      end
      // Random write and read back; conversion setup start and reserved bits kept clear
      repeat (25) begin
         i = 3'(2 + $urandom % 5);
         d = 8'($urandom);
         if (i == 3'h2) d = d & 8'h7E;
         apb(1'b1, adr(i), d);
         apb(1'b0, adr(i), 8'h00);
         chk("readback", rd[7:0], (i == 3'h6) ? d & 8'h7F : d);
      end
      apb(1'b1, adr(4), 8'hC5);
      #1 chk("prescaler", prescaler_select, 2'b11);
      chk("offset2", second_stage_offset, 4'h5);
      apb(1'b0, 8'h20, 8'h00);
      chk("unmapped", err, 1'b1);
      apb(1'b1, adr(0), 8'h5A);
      apb(1'b0, adr(0), 8'h00);
      chk("result_ro", rd[7:0], 8'h00);
      // Converter only, fastest settings, single shot
      apb(1'b1, adr(3), 8'hF1);
      @(posedge pclk);
      #1 chk("bypass", stage_bypass, 3'b111);
      apb(1'b1, adr(4), 8'h00);
      apb(1'b1, adr(2), 8'h80);
      @(posedge pclk);
      #1 chk("busy_start", busy, 1'b1);
      apb(1'b0, adr(2), 8'h00);
      chk("start_rd0", rd[7], 1'b0);
      apb(1'b1, adr(5), 8'h0C);
      #1 chk("stage_reset", stage_reset, 1'b1);
      chk("busy_kept", busy, 1'b1);
      wait_done();
      #1 chk("busy_end", busy, 1'b0);
      // Five ones in eight from the model give a quarter of full scale
      apb(1'b0, adr(0), 8'h00);
      chk("result_low", rd[7:0], mean_code(5, 8) & 16'h00FF);
      apb(1'b0, adr(1), 8'h00);
      chk("result_high", rd[7:0], mean_code(5, 8) >> 8);
      apb(1'b0, adr(7), 8'h00);
      chk("busy_rd", rd[7], 1'b0);
      // Continuous mode: a second done follows with no new start
      apb(1'b1, adr(2), 8'h82);
      wait_done();
      #1 wait_done();
      #1 chk("busy_free_running", busy, 1'b1);
      // Abort by clearing every enable
      apb(1'b1, adr(2), 8'h80);
      apb(1'b1, adr(3), 8'h00);
      @(posedge pclk);
      #1 chk("abort", busy, 1'b0);
      apb(1'b1, adr(3), 8'hF2);
      @(posedge pclk);
      #1 chk("bypass_on", stage_bypass, 3'b110);
      // Preset launch keeps the selectors written with it
      apb(1'b1, adr(5), 8'hFF);
      apb(1'b1, adr(7), 8'h6B);
      #1 chk("input_sel", input_selector, 5'h15);
      chk("ref_sel", reference_selector, 1'b1);
      chk("gain3_def", third_stage_gain, 7'h0C);
      chk("enable_def", power_enable, 4'h1);
      apb(1'b0, adr(7), 8'h00);
      chk("mux_rd", rd[7:0], 8'hAB);
      wrap_up();
   end
   initial begin
      #300000;
      fails++;
      wrap_up();
   end
endmodule // tb_zoom_adc_control_regs
